// [rtl/csp_serial_channel.sv]
`timescale 1ns/100ps
`default_nettype none

module csp_serial_channel
   import csp_pkg::*;
#(
   parameter int HALF_W = 8
) (
   input  wire logic        CLK_SYS_IN,          // system clock
   input  wire logic        RST_IN,              // async reset, active high
   input  wire logic        MODE_WR_IN,          // mode register write strobe
   input  wire logic [7:0]  MODE_WMASK_IN,       // bits written, all ones for byte
   input  wire logic [7:0]  MODE_WDATA_IN,       // mode write data
   output var  logic [7:0]  MODE_OUT,            // mode register read value
   input  wire logic        CLKSEL_WR_IN,        // clock select write strobe
   input  wire logic [7:0]  CLKSEL_WMASK_IN,     // bits written
   input  wire logic [7:0]  CLKSEL_WDATA_IN,     // clock select write data
   output var  logic [7:0]  CLKSEL_OUT,          // clock select read value
   input  wire logic [15:0] TX_WDATA_IN,         // data for all transmit writes
   input  wire logic        TX_WIDE_WR_IN,       // write wide transmit buffer
   input  wire logic        TX_BYTE_WR_IN,       // write byte transmit buffer
   input  wire logic        FIRST_TX_WIDE_WR_IN, // write wide initial buffer
   input  wire logic        FIRST_TX_BYTE_WR_IN, // write byte initial buffer
   output var  logic [15:0] TX_BUF_OUT,          // transmit buffer
   output var  logic [15:0] FIRST_TX_BUF_OUT,    // initial transmit buffer
   input  wire logic        RX_WIDE_RD_IN,       // read of wide receive buffer
   input  wire logic        RX_BYTE_RD_IN,       // read of byte receive buffer
   output var  logic [15:0] RX_BUF_WIDE_OUT,     // receive buffer
   output var  logic [7:0]  RX_BUF_BYTE_OUT,     // low byte of receive buffer
   output var  logic [15:0] RX_MIRROR_WIDE_OUT,  // mirror, reading starts nothing
   output var  logic [7:0]  RX_MIRROR_BYTE_OUT,  // mirror low byte
   output var  logic [15:0] SHIFT_REG_WIDE_OUT,  // shift register after transfer
   output var  logic [7:0]  SHIFT_REG_BYTE_OUT,  // its low byte
   output var  logic        XFER_ACTIVE_OUT,     // transfer in progress
   output var  logic        XFER_DONE_IRQ_OUT,   // completion pulse
   input  wire logic        SER_CLK_LINE_IN,     // level of the serial clock line
   output var  logic        SER_CLK_LINE_OUT,    // driven clock level
   output var  logic        SER_CLK_LINE_OE_OUT, // high while driving the clock
   input  wire logic        SER_DATA_IN,         // serial receive data
   output var  logic        SER_DATA_OUT         // serial transmit data
);

   if (HALF_W < 8) begin : g_bad_half_w
      $error("HALF_W too narrow for the slowest master clock");
   end

   // ---------------- system domain registers ----------------
   csp_mode_t         mode;
   csp_clksel_t       clksel;
   logic              active;
   logic              reserved;
   logic [15:0]       tx_buf;
   logic [15:0]       first_tx_buf;
   logic [15:0]       start_word;
   logic [15:0]       rx_buf;
   logic [15:0]       shift_snap;
   logic              irq;
   logic [HALF_W-1:0] half_cnt;
   logic [CNT_W:0]    rises;
   logic              sck_gen;
   logic              gen_done;
   logic              done_seen;

   // ---------------- link domain registers, and the synced done level ----------------
   logic [15:0]       shift_reg_wide;
   logic [CNT_W-1:0]  bit_cnt;
   logic              done_tgl;
   logic              ser_out;
   logic              done_lvl;

   wire               enable;
   wire               is_slave;
   wire               master_run;
   wire [3:0]         last_bit;
   wire [15:0]        word_mask;
   wire               start_req;
   wire               start_take;
   wire               done_evt;
   wire               kick;
   wire               link_arst;
   wire [7:0]         next_mode;
   wire [7:0]         next_clksel;
   wire [15:0]        next_tx_buf;
   wire [15:0]        next_first_tx;
   wire               next_reserved;
   wire [HALF_W-1:0]  half_last;
   wire               half_end;
   wire [15:0]        rx_word;

   assign enable     = mode.channel_enable;
   assign is_slave   = (clksel.clk_src_field == CLK_SRC_SLAVE);
   assign last_bit   = mode.word_len_sel ? LAST_BIT_WIDE : LAST_BIT_BYTE;
   assign word_mask  = mode.word_len_sel ? 16'hFFFF : 16'h00FF;

   // bit 0 of the mode register always shows the active flag
   assign next_mode  = MODE_WR_IN
                     ? ((mode & ~MODE_WMASK_IN) | (MODE_WDATA_IN & MODE_WMASK_IN))
                     : mode;

   // clock source is frozen while enabled so the divider never glitches
   assign next_clksel = (CLKSEL_WR_IN && !enable)
                      ? ((clksel & ~CLKSEL_WMASK_IN) | (CLKSEL_WDATA_IN & CLKSEL_WMASK_IN))
                      : clksel;

   assign next_tx_buf = TX_WIDE_WR_IN ? TX_WDATA_IN
                      : TX_BYTE_WR_IN ? {tx_buf[15:8], TX_WDATA_IN[7:0]}
                      : tx_buf;
   assign next_first_tx = FIRST_TX_WIDE_WR_IN ? TX_WDATA_IN
                        : FIRST_TX_BYTE_WR_IN ? {first_tx_buf[15:8], TX_WDATA_IN[7:0]}
                        : first_tx_buf;

   // only buffer strobes start a transfer; the mirrors and shift view have none
   assign start_req  = enable
                     && ((mode.duplex_mode_sel && (TX_WIDE_WR_IN || TX_BYTE_WR_IN))
                     || (!mode.duplex_mode_sel
                     && (RX_WIDE_RD_IN || RX_BYTE_RD_IN)));
   assign start_take = start_req && !active;

   // a reservation made in the completion cycle is kept, not lost
   assign next_reserved = (start_req && mode.repeat_sel && (active || start_take))
                        || (reserved && !done_evt);
   assign kick       = start_take || (done_evt && reserved);

   assign rx_word    = shift_reg_wide & word_mask;

   // ---------------- registers and buffers ----------------
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         mode         <= MODE_RESET;
         clksel       <= CLKSEL_RESET;
         tx_buf       <= BUF_RESET;
         first_tx_buf <= BUF_RESET;
      end else begin
         mode         <= {next_mode[7:2], 2'b00};
         clksel       <= next_clksel;
         tx_buf       <= next_tx_buf;
         first_tx_buf <= next_first_tx;
      end
   end

   // ---------------- transfer control ----------------
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         active     <= 1'b0;
         reserved   <= 1'b0;
         start_word <= BUF_RESET;
         rx_buf     <= BUF_RESET;
         shift_snap <= BUF_RESET;
         irq        <= 1'b0;
      end else if (!enable) begin
         active     <= 1'b0;
         reserved   <= 1'b0;
         rx_buf     <= BUF_RESET;
         shift_snap <= BUF_RESET;
         irq        <= 1'b0;
      end else begin
         irq      <= done_evt;
         reserved <= next_reserved;
         if (done_evt) begin
            rx_buf     <= rx_word;
            shift_snap <= rx_word;
            active     <= reserved;
            start_word <= next_tx_buf;
         end else if (start_take) begin
            active     <= 1'b1;
            start_word <= mode.repeat_sel ? next_first_tx : next_tx_buf;
         end
      end
   end

   // ---------------- master clock generator ----------------
   // half period doubles with each source code, 0 being the fastest
   assign half_last  = HALF_W'((MCLK_HALF_BASE << clksel.clk_src_field) - 1);
   assign half_end   = (half_cnt == half_last);
   assign master_run = active && !is_slave && !gen_done;

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         half_cnt <= '0;
         rises    <= '0;
         sck_gen  <= 1'b1;
         gen_done <= 1'b0;
      end else if (kick || !enable) begin
         half_cnt <= '0;
         rises    <= '0;
         sck_gen  <= 1'b1;
         gen_done <= 1'b0;
      end else if (master_run) begin
         half_cnt <= half_end ? '0 : half_cnt + 1'b1;
         if (half_end) begin
            sck_gen <= ~sck_gen;
            if (!sck_gen) begin
               rises    <= rises + 1'b1;
               // stop high after the last rising edge of the word
               gen_done <= (rises == {1'b0, last_bit});
            end
         end
      end
   end

   assign SER_CLK_LINE_OUT    = sck_gen;
   assign SER_CLK_LINE_OE_OUT = enable && !is_slave;

   // ---------------- link domain ----------------
   // the shifter runs on the line itself in both roles, so one register
   // serves master and slave; the line may stop between words
   assign link_arst = RST_IN || !enable;

   wire        first_edge;
   wire [15:0] shift_base;
   wire [15:0] shift_msb;
   wire [15:0] shift_lsb;
   wire        out_bit;

   // start_word is held steady by the system side while a word is on the line
   assign first_edge = (bit_cnt == '0);
   assign shift_base = first_edge ? (start_word & word_mask) : shift_reg_wide;
   assign shift_msb  = {shift_base[14:0], SER_DATA_IN} & word_mask;
   assign shift_lsb  = mode.word_len_sel ? {SER_DATA_IN, shift_base[15:1]}
                                         : {8'h00, SER_DATA_IN, shift_base[7:1]};
   assign out_bit    = mode.bit_order_sel ? shift_base[0] : shift_base[last_bit];

   always_ff @(posedge SER_CLK_LINE_IN or posedge link_arst) begin
      if (link_arst) begin
         shift_reg_wide <= BUF_RESET;
         bit_cnt        <= '0;
         done_tgl       <= 1'b0;
      end else begin
         // in and out move on the same edge, no one-way shifting exists
         shift_reg_wide <= mode.bit_order_sel ? shift_lsb : shift_msb;
         bit_cnt        <= (bit_cnt == last_bit) ? '0 : bit_cnt + 1'b1;
         if (bit_cnt == last_bit) begin
            done_tgl <= ~done_tgl;
         end
      end
   end

   // data changes on the falling edge, the far end samples on the rising one
   always_ff @(negedge SER_CLK_LINE_IN or posedge link_arst) begin
      if (link_arst) begin
         ser_out <= 1'b0;
      end else begin
         ser_out <= out_bit;
      end
   end

   // ---------------- completion crossing ----------------
   csp_sync #(
      .STAGES (3)
   ) u_done_sync (
      .clk_in (CLK_SYS_IN),
      .rst_in (link_arst),
      .d_in   (done_tgl),
      .q_out  (done_lvl)
   );

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         done_seen <= 1'b0;
      end else if (!enable) begin
         done_seen <= 1'b0;
      end else begin
         done_seen <= done_lvl;
      end
   end

   // the shift register is quiet once the toggle has crossed
   assign done_evt = enable && (done_lvl != done_seen);

   // ---------------- outputs ----------------
   assign MODE_OUT           = {mode[7:1], active};
   assign CLKSEL_OUT         = clksel;
   assign TX_BUF_OUT         = tx_buf;
   assign FIRST_TX_BUF_OUT   = first_tx_buf;
   assign RX_BUF_WIDE_OUT    = rx_buf;
   assign RX_BUF_BYTE_OUT    = rx_buf[7:0];
   assign RX_MIRROR_WIDE_OUT = rx_buf;
   assign RX_MIRROR_BYTE_OUT = rx_buf[7:0];
   assign SHIFT_REG_WIDE_OUT = shift_snap;
   assign SHIFT_REG_BYTE_OUT = shift_snap[7:0];
   assign XFER_ACTIVE_OUT    = active;
   assign XFER_DONE_IRQ_OUT  = irq;
   assign SER_DATA_OUT       = ser_out;

endmodule // csp_serial_channel

`default_nettype wire

// [rtl/csp_pkg.sv]
package csp_pkg;

   // system clock and fastest serial rate
   localparam int SYS_CLK_HZ        = 20_000_000;
   localparam int MAX_BIT_RATE_BPS  = 5_000_000;
   // shortest master half period in system cycles, derived from the two rates
   localparam int MCLK_HALF_BASE    = SYS_CLK_HZ / (2 * MAX_BIT_RATE_BPS);

   localparam int WORD_W            = 16;
   localparam int BYTE_W            = 8;
   localparam int CNT_W             = 4;

   // word lengths in serial clocks, minus one
   localparam logic [3:0] LAST_BIT_BYTE = 4'h7;
   localparam logic [3:0] LAST_BIT_WIDE = 4'hF;

   // clock-select field value that picks the external clock
   localparam logic [2:0] CLK_SRC_SLAVE = 3'h7;
   localparam int CLK_SRC_LSB       = 0;

   // mode register field positions
   localparam int MODE_ENABLE_POS   = 7;
   localparam int MODE_DUPLEX_POS   = 6;
   localparam int MODE_REPEAT_POS   = 5;
   localparam int MODE_WLEN_POS     = 4;
   localparam int MODE_ORDER_POS    = 3;
   localparam int MODE_DELAY_POS    = 2;
   localparam int MODE_ACTIVE_POS   = 0;

   localparam logic [7:0] MODE_RESET    = 8'h00;
   localparam logic [7:0] CLKSEL_RESET  = 8'h00;
   localparam logic [15:0] BUF_RESET    = 16'h0000;

   typedef struct packed {
      logic channel_enable;
      logic duplex_mode_sel;
      logic repeat_sel;
      logic word_len_sel;
      logic bit_order_sel;
      logic irq_delay_sel;
      logic spare;
      logic xfer_active_flag;
   } csp_mode_t;

   typedef struct packed {
      logic [4:0] spare;
      logic [2:0] clk_src_field;
   } csp_clksel_t;

endpackage : csp_pkg

// [rtl/csp_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module csp_sync #(
   parameter int STAGES = 3
) (
   input  wire logic clk_in,   // destination clock
   input  wire logic rst_in,   // asynchronous reset, active high
   input  wire logic d_in,     // level from another domain
   output var  logic q_out     // filtered level
);

   if (STAGES < 3) begin : g_bad_stages
      $error("csp_sync needs at least three stages");
   end

   logic [STAGES-1:0] stage;
   wire               agree;

   // the last two stages must agree before the output follows
   assign agree = (stage[STAGES-1] == stage[STAGES-2]);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         stage <= '0;
      end else begin
         stage <= {stage[STAGES-2:0], d_in};
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_out <= 1'b0;
      end else if (agree) begin
         q_out <= stage[STAGES-1];
      end
   end

endmodule // csp_sync

`default_nettype wire

// [verif/csp_serial_channel_props.sv]
`timescale 1ns/100ps
`default_nettype none

module csp_serial_channel_props
   import csp_pkg::*;
#(
   parameter int HALF_W = 8
) (
   input wire logic        CLK_SYS_IN,          // system clock
   input wire logic        RST_IN,              // reset
   input wire logic [7:0]  MODE_OUT,            // mode register
   input wire logic [7:0]  CLKSEL_OUT,          // clock select
   input wire logic        TX_WIDE_WR_IN,       // tx write
   input wire logic        TX_BYTE_WR_IN,       // tx write
   input wire logic        RX_WIDE_RD_IN,       // rx read
   input wire logic        RX_BYTE_RD_IN,       // rx read
   input wire logic [15:0] RX_BUF_WIDE_OUT,     // rx buffer
   input wire logic [7:0]  RX_BUF_BYTE_OUT,     // rx low byte
   input wire logic [15:0] RX_MIRROR_WIDE_OUT,  // mirror
   input wire logic [15:0] SHIFT_REG_WIDE_OUT,  // shifter copy
   input wire logic        XFER_ACTIVE_OUT,     // busy
   input wire logic        XFER_DONE_IRQ_OUT,   // done pulse
   input wire logic        SER_CLK_LINE_IN,     // clock line
   input wire logic        SER_CLK_LINE_OE_OUT  // clock drive
);
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);

   wire logic idle_on = MODE_OUT[MODE_ENABLE_POS] & ~XFER_ACTIVE_OUT;
   wire logic wide    = MODE_OUT[MODE_WLEN_POS];
   wire logic duplex  = MODE_OUT[MODE_DUPLEX_POS];
   wire logic single  = ~MODE_OUT[MODE_REPEAT_POS];
   wire logic slave   = CLKSEL_OUT[CLK_SRC_LSB +: 3] == CLK_SRC_SLAVE;
   wire logic tx_go   = idle_on & duplex & (wide ? TX_WIDE_WR_IN : TX_BYTE_WR_IN);
   wire logic rx_go   = idle_on & ~duplex & (wide ? RX_WIDE_RD_IN : RX_BYTE_RD_IN);

   // rises of the line seen while busy; each level lasts over one system cycle
   logic       line_q;
   logic [4:0] rise_cnt;
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         line_q   <= 1'h1;
         rise_cnt <= 5'h00;
      end else begin
         line_q   <= SER_CLK_LINE_IN;
         rise_cnt <= XFER_ACTIVE_OUT ? rise_cnt + 5'(SER_CLK_LINE_IN & ~line_q) : 5'h00;
      end
   end

   start_tx_a: assert property (tx_go |=> XFER_ACTIVE_OUT)
      else $error("transmit write did not start a transfer");
   start_rx_a: assert property (rx_go |=> XFER_ACTIVE_OUT)
      else $error("receive read did not start a transfer");
   no_start_a: assert property (
      idle_on && !tx_go && !rx_go |=> !XFER_ACTIVE_OUT)
      else $error("transfer started without a start access");
   irq_pulse_a: assert property (XFER_DONE_IRQ_OUT |=> !XFER_DONE_IRQ_OUT)
      else $error("completion pulse longer than one cycle");
   done_idle_a: assert property (
      XFER_DONE_IRQ_OUT && single |-> !XFER_ACTIVE_OUT && $past(XFER_ACTIVE_OUT))
      else $error("completion without ending a transfer");
   word_count_a: assert property (
      XFER_DONE_IRQ_OUT && single |-> rise_cnt == (wide ? 5'h10 : 5'h08))
      else $error("clock count differs from word length");
   bit0_ro_a: assert property (
      MODE_OUT[MODE_ACTIVE_POS] == XFER_ACTIVE_OUT && !MODE_OUT[1])
      else $error("mode bit 0 does not follow the busy flag");
   slave_oe_a: assert property (slave |-> !SER_CLK_LINE_OE_OUT)
      else $error("clock line driven in slave role");
   master_oe_a: assert property (
      (MODE_OUT[MODE_ENABLE_POS] && !slave) [*3] |-> SER_CLK_LINE_OE_OUT)
      else $error("clock line not driven in master role");
   rx_alias_a: assert property (
      RX_BUF_BYTE_OUT == RX_BUF_WIDE_OUT[7:0] && RX_MIRROR_WIDE_OUT == RX_BUF_WIDE_OUT)
      else $error("receive views disagree");
   disable_clear_a: assert property (
      (!MODE_OUT[MODE_ENABLE_POS]) [*3]
      |-> RX_BUF_WIDE_OUT == BUF_RESET && SHIFT_REG_WIDE_OUT == BUF_RESET)
      else $error("buffers not cleared while disabled");

   cover property (tx_go);
   cover property (rx_go);
   cover property (XFER_DONE_IRQ_OUT && slave);
   cover property (XFER_DONE_IRQ_OUT && XFER_ACTIVE_OUT);
endmodule // csp_serial_channel_props

bind csp_serial_channel csp_serial_channel_props #(.HALF_W(HALF_W)) i_csp_serial_channel_props (
   .CLK_SYS_IN, .RST_IN, .MODE_OUT, .CLKSEL_OUT, .TX_WIDE_WR_IN, .TX_BYTE_WR_IN,
   .RX_WIDE_RD_IN, .RX_BYTE_RD_IN, .RX_BUF_WIDE_OUT, .RX_BUF_BYTE_OUT, .RX_MIRROR_WIDE_OUT,
   .SHIFT_REG_WIDE_OUT, .XFER_ACTIVE_OUT, .XFER_DONE_IRQ_OUT, .SER_CLK_LINE_IN,
   .SER_CLK_LINE_OE_OUT);

`default_nettype wire

// [verif/csp_far_end.sv]
`timescale 1ns/100ps
`default_nettype none

module csp_far_end (
   input  wire logic        line_in,  // resolved clock line
   input  wire logic        rst_in,   // clears bit count
   input  wire logic        go_in,    // rise runs one frame
   input  wire logic [4:0]  nbits_in, // word length
   input  wire logic        lsb_in,   // low bit first
   input  wire logic [15:0] tx_in,    // word to send
   input  wire logic        din_in,   // data from channel
   output var  logic        clk_out,  // clock as master
   output var  logic        oe_out,   // high while driving clock
   output var  logic        dout_out, // data to channel
   output var  logic [15:0] rx_out    // word received
);
   int k = 0;
   wire logic [3:0] pos = lsb_in ? 4'(k) : 4'(nbits_in - 5'h01 - 5'(k));

   initial begin
      {clk_out, oe_out, dout_out} = 3'h4;
      rx_out = 16'h0000;
   end

   // exactly one word of clocks, then the clock stands high
   always @(posedge go_in) begin
      #17 oe_out = 1'h1;
      repeat (nbits_in) begin
         #62.5 clk_out = 1'h0;
         #62.5 clk_out = 1'h1;
      end
      #20 oe_out = 1'h0;
   end

   always @(negedge line_in) dout_out = tx_in[pos];

   always @(posedge line_in or posedge rst_in) begin
      if (rst_in) begin
         k = 0;
      end else begin
         rx_out[pos] = din_in;
         k = k + 1;
         if (k == int'(nbits_in)) begin
            k = 0;
            // stale bit inverted so a late sample cannot pass
            #20 dout_out = ~dout_out;
         end
      end
   end
endmodule // csp_far_end

`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_top
   import csp_pkg::*;
;
   logic        clk, rst, go, plsb, oe, poe, pclk, lo, dout, din, act, irq;
   logic [7:0]  stb, wm, wd, mode, clks, rxb, mb, sb;
   logic [15:0] txd, txb, ftx, rxw, mw, sw, ptx, prx;
   logic [4:0]  nb;
   wire logic   line = oe ? lo : (poe ? pclk : 1'h1); // pull-up holds idle high
   int          mismatches, comparisons, rises;
   logic [15:0] q[$];
   logic [31:0] seed = 32'h0000_43C6;

   csp_serial_channel #(.HALF_W(8)) i_csp_serial_channel (
      .CLK_SYS_IN(clk), .RST_IN(rst), .MODE_WR_IN(stb[0]), .MODE_WMASK_IN(wm),
      .MODE_WDATA_IN(wd), .MODE_OUT(mode), .CLKSEL_WR_IN(stb[1]), .CLKSEL_WMASK_IN(wm),
      .CLKSEL_WDATA_IN(wd), .CLKSEL_OUT(clks), .TX_WDATA_IN(txd), .TX_WIDE_WR_IN(stb[2]),
      .TX_BYTE_WR_IN(stb[3]), .FIRST_TX_WIDE_WR_IN(stb[4]), .FIRST_TX_BYTE_WR_IN(stb[5]),
      .TX_BUF_OUT(txb), .FIRST_TX_BUF_OUT(ftx), .RX_WIDE_RD_IN(stb[6]),
      .RX_BYTE_RD_IN(stb[7]), .RX_BUF_WIDE_OUT(rxw), .RX_BUF_BYTE_OUT(rxb),
      .RX_MIRROR_WIDE_OUT(mw), .RX_MIRROR_BYTE_OUT(mb), .SHIFT_REG_WIDE_OUT(sw),
      .SHIFT_REG_BYTE_OUT(sb), .XFER_ACTIVE_OUT(act), .XFER_DONE_IRQ_OUT(irq),
      .SER_CLK_LINE_IN(line), .SER_CLK_LINE_OUT(lo), .SER_CLK_LINE_OE_OUT(oe),
      .SER_DATA_IN(din), .SER_DATA_OUT(dout));

   csp_far_end i_csp_far_end (
      .line_in(line), .rst_in(rst), .go_in(go), .nbits_in(nb), .lsb_in(plsb),
      .tx_in(ptx), .din_in(dout), .clk_out(pclk), .oe_out(poe), .dout_out(din),
      .rx_out(prx));

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   always @(posedge line) rises++;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task cyc;
      @(posedge clk);
      #5;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // strobe low for a cycle after each pulse, so no signal changes twice at once
   task pulse(input int idx);
      stb[idx] = 1'h1;
      cyc;
      stb = 8'h00;
      cyc;
   endtask

   task wr(input int idx, input logic [7:0] m, input logic [7:0] d);
      wm = m;
      wd = d;
      pulse(idx);
   endtask

   task results;
      $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // steps past a pulse still showing, so back-to-back waits see the next one
   task wait_irq;
      int n;
      cyc;
      for (n = 1; n < 6000 && irq !== 1'h1; n++) cyc;
      if (irq !== 1'h1) begin
         mismatches++;
         results;
      end
   endtask

   task automatic xfer(input logic [2:0] src, input logic wide, input logic lsb,
                       input logic rxo);
      logic [15:0] m;
      logic [15:0] dt;
      logic [15:0] e;
      m = wide ? 16'hFFFF : 16'h00FF;
      dt = 16'(rnd());
      wr(0, 8'hFF, 8'h00);
      chk(rxw, BUF_RESET);
      wr(1, 8'hFF, {5'h00, src});
      wr(0, 8'hFF, {1'h1, ~rxo, 1'h0, wide, lsb, 3'h0});
      wr(1, 8'hFF, 8'h05);
      chk(16'(clks), {13'h0000, src});
      txd = dt;
      pulse(wide ? 4 : 5);
      chk(ftx & m, dt & m);
      if (rxo) pulse(wide ? 2 : 3);
      chk(16'(act), 16'h0000);
      nb = wide ? 5'h10 : 5'h08;
      plsb = lsb;
      ptx = 16'(rnd());
      q.push_back(ptx & m);
      rises = 0;
      pulse(rxo ? (wide ? 6 : 7) : (wide ? 2 : 3));
      chk(16'(act), 16'h0001);
      chk(txb & m, dt & m);
      if (src == CLK_SRC_SLAVE) begin
         go = 1'h1;
         cyc;
         go = 1'h0;
      end
      wait_irq;
      e = q.pop_front();
      chk(16'(act), 16'h0000);
      chk(rxw & m, e);
      chk({rxb, mb}, {e[7:0], e[7:0]});
      chk(mw & m, e);
      chk({sw[15:8] & m[15:8], sb}, e);
      chk(16'(rises), 16'(nb));
      if (!rxo) chk(prx & m, dt & m);
      $display("transfer with source %0d done", src);
   endtask

   initial begin
      {rst, go, plsb} = 3'h4;
      {stb, wm, wd, txd, ptx} = '0;
      nb = 5'h08;
      repeat (10) cyc;
      rst = 1'h0;
      cyc;
      chk({mode, clks}, {MODE_RESET, CLKSEL_RESET});
      chk(rxw, BUF_RESET);
      chk({14'h0000, lo, oe}, 16'h0002);
      wr(0, 8'h03, 8'h03);
      chk(16'(mode), 16'h0000);
      wr(0, 8'h08, 8'h08);
      chk(16'(mode), 16'h0008);
      $display("register test done");
      for (int i = 0; i < 10; i++) begin
         xfer(i < 7 ? 3'(i) : 3'h7, i[0], i[1], i[2]);
      end
      // repeat mode: the initial word goes first, the reserved buffer word follows
      wr(0, 8'hFF, 8'h00);
      wr(1, 8'hFF, 8'h00);
      wr(0, 8'hFF, 8'hE0);
      nb = 5'h08;
      plsb = 1'h0;
      ptx = 16'(rnd());
      txd = 16'(rnd());
      q.push_back(txd & 16'h00FF);
      pulse(5);
      txd = 16'(rnd());
      q.push_back(txd & 16'h00FF);
      pulse(3);
      chk(16'(act), 16'h0001);
      wait_irq;
      chk(16'(act), 16'h0001);
      chk(prx & 16'h00FF, q.pop_front());
      chk(rxw, ptx & 16'h00FF);
      wait_irq;
      chk(16'(act), 16'h0000);
      chk(prx & 16'h00FF, q.pop_front());
      chk(rxw, ptx & 16'h00FF);
      $display("repeat transfer done");
      results;
   end
endmodule // tb_top

`default_nettype wire
